// ### core/aim_pkg.sv
package aim_pkg;
  localparam int         MCLK_PERIOD_NS    = 40;
  localparam int         AUX_SCL_PERIOD_NS = 2500;
  localparam int         AUX_QTR_CYC       =
    (AUX_SCL_PERIOD_NS + 4 * MCLK_PERIOD_NS - 1) / (4 * MCLK_PERIOD_NS);
  localparam int         FETCH_PERIOD_US   = 5000;
  localparam int         FETCH_PERIOD_CYC  =
    FETCH_PERIOD_US * 1000 / MCLK_PERIOD_NS;
  localparam int         NUM_MCH           = 4;
  localparam int         LEN_W             = 5;
  localparam int         NB                = 24;
  localparam logic [4:0] MAX_FETCH_BYTES   = 5'h18;
  // arbitrary upper bits of the own slave address
  localparam logic [5:0] OWN_ADDR_HI       = 6'h2A;
  localparam logic [6:0] MAG_ADDR          = 7'h0C;
  localparam logic [2:0] CH4               = 3'h4;
  localparam logic [2:0] CH_END            = 3'h5;
  localparam logic [3:0] ACK_SLOT          = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_NEXT, ST_START, ST_BYTE, ST_STOP
  } aim_state_t;
  typedef enum logic [2:0] {
    T_ADDRW, T_REG, T_ADDRR, T_DATAW, T_DATAR
  } aim_step_t;
endpackage

// ### core/aim_aux_master.sv
`timescale 1ns/100ps
`default_nettype none
module aim_aux_master #(
  parameter int FETCH_CYC = aim_pkg::FETCH_PERIOD_CYC
) (
  // clocks and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        hostClk,
  // mode and channel 0-3 setup, mclk domain
  input  wire logic                        masterEn,
  input  wire logic                        bypassEn,
  input  wire logic                        spiMode,
  input  wire logic [aim_pkg::NUM_MCH-1:0] chanEn,
  input  wire logic [aim_pkg::NUM_MCH-1:0] chanFifo,
  input  wire logic [aim_pkg::NUM_MCH*7-1:0] chanAddr,
  input  wire logic [aim_pkg::NUM_MCH*8-1:0] chanReg,
  input  wire logic [aim_pkg::NUM_MCH*aim_pkg::LEN_W-1:0] chanLen,
  // channel 4 command and result, hostClk domain
  input  wire logic                        ch4Go,
  input  wire logic                        ch4Write,
  input  wire logic [6:0]                  ch4Addr,
  input  wire logic [7:0]                  ch4Reg,
  input  wire logic [7:0]                  ch4WrData,
  output logic      [7:0]                  ch4RdData,
  output logic                             ch4Done,
  output logic                             ch4Nack,
  // external sensor data, hostClk domain
  output logic      [aim_pkg::NB*8-1:0]    extData,
  output logic                             extUpdate,
  // fifo feed and nack event, mclk domain
  output logic      [7:0]                  fifoData,
  output logic                             fifoPush,
  output logic                             auxNack,
  output logic      [2:0]                  auxNackChan,
  // primary port
  input  wire logic                        slaveAddrLsbPin,
  output logic      [6:0]                  ownSlaveAddr,
  output logic                             bypassSwitch,
  // aux bus pins
  input  wire logic                        auxSerialDataIn,
  output logic                             auxSerialDataOut,
  output logic                             auxSerialDataOe,
  input  wire logic                        auxSerialClockIn,
  output logic                             auxSerialClockOut,
  output logic                             auxSerialClockOe
);
  import aim_pkg::*;
  localparam int         FW   = $clog2(FETCH_CYC);
  localparam logic [7:0] QMAX = 8'(AUX_QTR_CYC - 1);

  aim_state_t    state;
  aim_step_t     step;
  logic [1:0]    ph;
  logic [7:0]    qCnt;
  logic [3:0]    bitCnt;
  logic [7:0]    shReg;
  logic          sampleBit;
  logic [2:0]    chan;
  logic [4:0]    idx;
  logic [4:0]    remain;
  logic [FW-1:0] fetchCnt;
  logic [7:0]    dataBuf [NB];
  logic [NB*8-1:0] bufFlat;
  logic [1:0]    sdaS, sclS, ad0S, ackS;
  logic [2:0]    goS;
  logic          pubTog, doneTog, ch4Pend, ch4NackReg;
  logic [7:0]    ch4Rd;
  logic          next_dataOe, next_clockOe;
  logic          goTog, hostAck;
  logic [2:0]    doneS, pubS;

  wire       switchOn  = bypassEn & ~spiMode;
  wire       masterRun = masterEn & ~switchOn;
  wire       sdaHigh   = sdaS[1];
  wire       sclHigh   = sclS[1];
  wire       qDone     = qCnt == QMAX;
  wire       tick      = qDone && !(ph == 2'h1 && !sclHigh);
  wire       onBus     = state == ST_START || state == ST_BYTE ||
                         state == ST_STOP;
  wire       lastQ     = tick && ph == 2'h3;
  wire       isCh4     = chan == CH4;
  wire       doWrite   = isCh4 && ch4Write;
  wire       rxByte    = step == T_DATAR;
  // no byte completes once the master is switched off mid-transfer
  wire       byteEnd   = masterRun && state == ST_BYTE && lastQ &&
                         bitCnt == ACK_SLOT;
  wire       nackSeen  = byteEnd && !rxByte && sampleBit;
  wire       bufWe     = byteEnd && rxByte && !isCh4;
  wire [1:0] ci        = chan[1:0];
  wire [6:0] curAddr   = isCh4 ? ch4Addr : chanAddr[ci*7 +: 7];
  wire [7:0] curReg    = isCh4 ? ch4Reg : chanReg[ci*8 +: 8];
  wire [4:0] curLen    = chanLen[ci*LEN_W +: LEN_W];
  wire [4:0] room      = MAX_FETCH_BYTES - idx;
  wire [4:0] lenClip   = curLen > room ? room : curLen;
  wire       pubReady  = ackS[1] == pubTog;
  wire       fetchDue  = fetchCnt == FW'(FETCH_CYC - 1);
  wire       chanGo    = chan < CH4 ? chanEn[ci] && lenClip != 5'h0
                                    : isCh4 && ch4Pend;
  wire       goEdge    = goS[2] ^ goS[1];
  wire       txLow     = bitCnt != ACK_SLOT ? !rxByte && !shReg[7]
                                            : rxByte && remain != 5'h1;

  // open-drain line levels per phase of the current bus state
  always_comb begin
    next_dataOe  = 1'b0;
    next_clockOe = 1'b0;
    if (masterRun) begin
      unique case (state)
        ST_START: begin
          next_dataOe  = ph[1];
          next_clockOe = ph == 2'h3 || (ph == 2'h0 && auxSerialClockOe);
        end
        ST_BYTE: begin
          next_dataOe  = txLow;
          next_clockOe = ph == 2'h0 || ph == 2'h3;
        end
        ST_STOP: begin
          next_dataOe  = !ph[1];
          next_clockOe = ph == 2'h0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      auxSerialDataOe   <= 1'b0;
      auxSerialClockOe  <= 1'b0;
      auxSerialDataOut  <= 1'b0;
      auxSerialClockOut <= 1'b0;
      sdaS              <= 2'h0;
      sclS              <= 2'h0;
      ad0S              <= 2'h0;
      ackS              <= 2'h0;
      goS               <= 3'h0;
      ownSlaveAddr      <= 7'h00;
      bypassSwitch      <= 1'b0;
    end else begin
      auxSerialDataOe   <= next_dataOe;
      auxSerialClockOe  <= next_clockOe;
      auxSerialDataOut  <= 1'b0;
      auxSerialClockOut <= 1'b0;
      sdaS              <= {sdaS[0], auxSerialDataIn};
      sclS              <= {sclS[0], auxSerialClockIn};
      ad0S              <= {ad0S[0], slaveAddrLsbPin};
      ackS              <= {ackS[0], hostAck};
      goS               <= {goS[1:0], goTog};
      // slave address stays live in every mode
      ownSlaveAddr      <= {OWN_ADDR_HI, ad0S[1]};
      bypassSwitch      <= switchOn;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      qCnt     <= 8'h00;
      fetchCnt <= '0;
      ch4Pend  <= 1'b0;
    end else begin
      qCnt     <= (!onBus || tick) ? 8'h00 : qDone ? qCnt : qCnt + 8'h01;
      if (state == ST_IDLE && masterRun && fetchDue && pubReady)
        fetchCnt <= '0;
      else if (!fetchDue)
        fetchCnt <= fetchCnt + FW'(1);
      // a new request wins over the completion clear
      if (goEdge)
        ch4Pend <= 1'b1;
      else if (state == ST_STOP && lastQ && isCh4)
        ch4Pend <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (bufWe)
      dataBuf[idx] <= shReg;
  end

  for (genvar g = 0; g < NB; g++) begin : g_flat
    assign bufFlat[g*8 +: 8] = dataBuf[g];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      step        <= T_ADDRW;
      ph          <= 2'h0;
      bitCnt      <= 4'h0;
      shReg       <= 8'h00;
      sampleBit   <= 1'b0;
      chan        <= 3'h0;
      idx         <= 5'h00;
      remain      <= 5'h00;
      pubTog      <= 1'b0;
      doneTog     <= 1'b0;
      ch4Rd       <= 8'h00;
      ch4NackReg  <= 1'b0;
      auxNack     <= 1'b0;
      auxNackChan <= 3'h0;
      fifoPush    <= 1'b0;
      fifoData    <= 8'h00;
    end else if (!masterRun) begin
      state   <= ST_IDLE;
      ph      <= 2'h0;
      auxNack <= 1'b0;
      fifoPush <= 1'b0;
    end else begin
      auxNack  <= nackSeen;
      fifoPush <= bufWe && chanFifo[ci];
      if (bufWe)
        fifoData <= shReg;
      if (nackSeen)
        auxNackChan <= chan;
      if (onBus && tick)
        ph <= ph + 2'h1;
      if (state == ST_BYTE && tick && ph == 2'h2)
        sampleBit <= sdaHigh;
      unique case (state)
        ST_IDLE: if (fetchDue && pubReady) begin
          state <= ST_NEXT;
          chan  <= 3'h0;
          idx   <= 5'h00;
        end
        ST_NEXT: if (chan == CH_END) begin
          pubTog <= ~pubTog;
          state  <= ST_IDLE;
        end else if (chanGo) begin
          state  <= ST_START;
          step   <= T_ADDRW;
          shReg  <= {curAddr, 1'b0};
          remain <= isCh4 ? 5'h01 : lenClip;
          if (isCh4)
            ch4NackReg <= 1'b0;
        end else begin
          chan <= chan + 3'h1;
        end
        ST_START: if (lastQ) begin
          state  <= ST_BYTE;
          bitCnt <= 4'h0;
        end
        ST_BYTE: if (lastQ) begin
          if (bitCnt != ACK_SLOT) begin
            bitCnt <= bitCnt + 4'h1;
            shReg  <= {shReg[6:0], sampleBit};
          end else begin
            bitCnt <= 4'h0;
            if (nackSeen) begin
              state <= ST_STOP;
              if (isCh4)
                ch4NackReg <= 1'b1;
              else
                idx <= idx + remain;
            end else begin
              unique case (step)
                T_ADDRW: begin
                  step  <= T_REG;
                  shReg <= curReg;
                end
                T_REG: if (doWrite) begin
                  step  <= T_DATAW;
                  shReg <= ch4WrData;
                end else begin
                  step  <= T_ADDRR;
                  shReg <= {curAddr, 1'b1};
                  state <= ST_START;
                end
                T_ADDRR: step <= T_DATAR;
                T_DATAW: state <= ST_STOP;
                T_DATAR: begin
                  remain <= remain - 5'h01;
                  if (remain == 5'h01)
                    state <= ST_STOP;
                  if (isCh4)
                    ch4Rd <= shReg;
                  else
                    idx <= idx + 5'h01;
                end
                default: ;
              endcase
            end
          end
        end
        ST_STOP: if (lastQ) begin
          state <= ST_NEXT;
          chan  <= chan + 3'h1;
          if (isCh4)
            doneTog <= ~doneTog;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // host side: command toggle out, results and data copied on toggles
  always_ff @(posedge hostClk or negedge rst_b) begin
    if (!rst_b) begin
      goTog     <= 1'b0;
      hostAck   <= 1'b0;
      doneS     <= 3'h0;
      pubS      <= 3'h0;
      ch4Done   <= 1'b0;
      ch4Nack   <= 1'b0;
      ch4RdData <= 8'h00;
      extUpdate <= 1'b0;
      extData   <= '0;
    end else begin
      if (ch4Go)
        goTog <= ~goTog;
      doneS     <= {doneS[1:0], doneTog};
      pubS      <= {pubS[1:0], pubTog};
      ch4Done   <= doneS[2] ^ doneS[1];
      extUpdate <= pubS[2] ^ pubS[1];
      if (doneS[2] ^ doneS[1]) begin
        ch4RdData <= ch4Rd;
        ch4Nack   <= ch4NackReg;
      end
      if (pubS[2] ^ pubS[1]) begin
        extData <= bufFlat;
        hostAck <= pubS[1];
      end
    end
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_bypass_release;
    bypassSwitch |-> !auxSerialDataOe && !auxSerialClockOe;
  endproperty
  a_bypass_release: assert property (p_bypass_release)
    else $error("aux lines driven while bypass is closed");

  property p_spi_no_bypass;
    spiMode |=> !bypassSwitch;
  endproperty
  a_spi_no_bypass: assert property (p_spi_no_bypass)
    else $error("bypass switch closed in spi mode");

  property p_addr_lsb;
    $past(rst_b, 3) |-> ownSlaveAddr[0] == $past(slaveAddrLsbPin, 3);
  endproperty
  a_addr_lsb: assert property (p_addr_lsb)
    else $error("slave address lsb does not follow its pin");

  property p_own_addr_bypass;
    bypassSwitch |-> ownSlaveAddr[6:1] == OWN_ADDR_HI;
  endproperty
  a_own_addr_bypass: assert property (p_own_addr_bypass)
    else $error("own slave address lost during bypass");

  property p_master_off;
    !masterRun |=> state == ST_IDLE && !auxSerialClockOe;
  endproperty
  a_master_off: assert property (p_master_off)
    else $error("master active while disabled");

  property p_auto_fetch;
    state == ST_IDLE && masterRun && fetchDue && pubReady |=>
      state == ST_NEXT && chan == 3'h0;
  endproperty
  a_auto_fetch: assert property (p_auto_fetch)
    else $error("due fetch cycle did not start");

  property p_idx_cap;
    idx <= MAX_FETCH_BYTES;
  endproperty
  a_idx_cap: assert property (p_idx_cap)
    else $error("fetch cycle exceeded its byte budget");

  property p_ch4_nack_last;
    state == ST_BYTE && rxByte && isCh4 && bitCnt == ACK_SLOT &&
      ph == 2'h2 |-> !auxSerialDataOe;
  endproperty
  a_ch4_nack_last: assert property (p_ch4_nack_last)
    else $error("channel 4 acknowledged more than one byte");

  property p_wr_single;
    byteEnd && step == T_DATAW |=> state == ST_STOP;
  endproperty
  a_wr_single: assert property (p_wr_single)
    else $error("channel 4 write went beyond one byte");

  property p_ch4_wr_data;
    byteEnd && step == T_REG && doWrite && !nackSeen |=>
      step == T_DATAW && shReg == $past(ch4WrData);
  endproperty
  a_ch4_wr_data: assert property (p_ch4_wr_data)
    else $error("channel 4 write data not loaded");

  property p_read_store;
    bufWe |=> idx == 5'($past(idx) + 5'h01);
  endproperty
  a_read_store: assert property (p_read_store)
    else $error("read byte not stored at next index");

  property p_fifo_push;
    fifoPush |-> $past(bufWe) && fifoData == $past(shReg);
  endproperty
  a_fifo_push: assert property (p_fifo_push)
    else $error("fifo push without a stored channel byte");

  property p_start_cond;
    $rose(auxSerialDataOe) && !auxSerialClockOe |-> state == ST_START;
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("sda fell with scl high outside start");

  property p_nack_abort;
    auxNack |-> state == ST_STOP ##[1:1000] state == ST_NEXT;
  endproperty
  a_nack_abort: assert property (p_nack_abort)
    else $error("nack did not end in a stop");

  c_publish: cover property (state == ST_NEXT && chan == CH_END);
  c_ch4_write: cover property (byteEnd && step == T_DATAW);
  c_nack: cover property (auxNack);
  c_mag: cover property (state == ST_START && isCh4 && ch4Addr == MAG_ADDR);
  c_bypass: cover property (bypassSwitch);
endmodule
`default_nettype wire

// ### verif/aim_aux_sensor.sv
`timescale 1ns/100ps
`default_nettype none
module aim_aux_sensor #(
  parameter logic [6:0] ADDR = 7'h0C
) (
  // resolved bus wires
  input  wire logic scl,
  input  wire logic sda,
  // stretch the clock after each falling edge unless idle (mode 3)
  input  wire logic slow,
  // open-drain pull-downs
  output logic      sclOe,
  output logic      sdaOe
);
  logic [7:0] mem [256];
  logic [7:0] ptr;
  logic [7:0] sh;
  logic [7:0] tx;
  logic       rdDir;
  logic       first;
  int         bitN;
  // 0 address, 1 write, 2 read, 3 idle
  int         mode;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    ptr = 8'h00;
    mode = 3;
    bitN = 0;
    sclOe = 1'b0;
    sdaOe = 1'b0;
  end

  // start or repeated start
  always @(negedge sda) if (scl === 1'b1) begin
    bitN = -1;
    mode = 0;
    sdaOe = 1'b0;
  end

  // stop
  always @(posedge sda) if (scl === 1'b1) mode = 3;

  always @(posedge scl) if (mode != 3) begin
    if (bitN < 8) sh = {sh[6:0], sda};
    else if (mode == 2 && sda === 1'b1) mode = 3;
  end

  always @(negedge scl) if (mode != 3) begin
    // scl is held first, then data moves; the hold lasts past the master's low phase
    if (slow) sclOe = 1'b1;
    bitN = bitN + 1;
    if (bitN == 8) begin
      // answer only our own address
      if (mode == 0 && sh[7:1] != ADDR) mode = 3;
      if (mode == 0) begin
        rdDir = sh[0];
        first = 1'b1;
      end else if (mode == 1) begin
        // first byte points, later bytes land in successive registers
        if (first) ptr = sh;
        else begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
        first = 1'b0;
      end
      sdaOe = (mode == 0 || mode == 1);
    end else if (bitN == 9) begin
      bitN = 0;
      sdaOe = 1'b0;
      if (mode == 0) mode = rdDir ? 2 : 1;
      if (mode == 2) begin
        tx = mem[ptr];
        ptr = ptr + 8'h01;
      end
    end
    if (mode == 2 && bitN < 8) sdaOe = !tx[7 - bitN];
    if (slow) begin
      #2000;
      sclOe = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verif/aux_i2c_master_bypass_test.sv
`timescale 1ns/100ps
`default_nettype none
module aux_i2c_master_bypass_test;
  import aim_pkg::*;
  logic        mclk, rst_b, hostClk, masterEn, bypassEn, spiMode, slow;
  logic [3:0]  chanEn, chanFifo;
  logic [27:0] chanAddr;
  logic [31:0] chanReg;
  logic [19:0] chanLen;
  logic        ch4Go, ch4Write, ch4Done, ch4Nack, extUpdate, fifoPush;
  logic [6:0]  ch4Addr, ownSlaveAddr;
  logic [7:0]  ch4Reg, ch4WrData, ch4RdData, fifoData;
  logic [191:0] extData;
  logic        auxNack, slaveAddrLsbPin, bypassSwitch;
  logic [2:0]  auxNackChan, nackCh;
  logic        sdaOe, sclOe, sensSdaOe, sensSclOe, sdaOut, sclOut;
  logic [7:0]  fifoQ[$];
  int          nackSeen, oeSeen, mismatches, nCompared;
  wire logic   sdaWire = !(sdaOe | sensSdaOe);
  wire logic   sclWire = !(sclOe | sensSclOe);

  aim_aux_master #(.FETCH_CYC(400)) DUT (
    .mclk(mclk), .rst_b(rst_b), .hostClk(hostClk), .masterEn(masterEn),
    .bypassEn(bypassEn), .spiMode(spiMode), .chanEn(chanEn),
    .chanFifo(chanFifo), .chanAddr(chanAddr), .chanReg(chanReg),
    .chanLen(chanLen), .ch4Go(ch4Go), .ch4Write(ch4Write),
    .ch4Addr(ch4Addr), .ch4Reg(ch4Reg), .ch4WrData(ch4WrData),
    .ch4RdData(ch4RdData), .ch4Done(ch4Done), .ch4Nack(ch4Nack),
    .extData(extData), .extUpdate(extUpdate), .fifoData(fifoData),
    .fifoPush(fifoPush), .auxNack(auxNack), .auxNackChan(auxNackChan),
    .slaveAddrLsbPin(slaveAddrLsbPin), .ownSlaveAddr(ownSlaveAddr),
    .bypassSwitch(bypassSwitch), .auxSerialDataIn(sdaWire),
    .auxSerialDataOut(sdaOut), .auxSerialDataOe(sdaOe),
    .auxSerialClockIn(sclWire), .auxSerialClockOut(sclOut),
    .auxSerialClockOe(sclOe));

  aim_aux_sensor #(.ADDR(MAG_ADDR)) sensor (
    .scl(sclWire), .sda(sdaWire), .slow(slow),
    .sclOe(sensSclOe), .sdaOe(sensSdaOe));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    hostClk = 1'b0;
    #13;
    forever #80 hostClk = ~hostClk;
  end

  always @(posedge mclk) begin
    if (fifoPush === 1'b1) fifoQ.push_back(fifoData);
    if (auxNack === 1'b1) begin
      nackSeen++;
      nackCh = auxNackChan;
    end
    if (sdaOe === 1'b1 || sclOe === 1'b1) oeSeen++;
  end

  task automatic tallyAndFinish();
    $display("compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp, input string what);
    cmpByte({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic mcyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic waitHost(input logic wantDone);
    for (int i = 0; i < 10000; i++) begin
      @(posedge hostClk);
      #2;
      if ((wantDone ? ch4Done : extUpdate) === 1'b1) return;
    end
    mismatches++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    tallyAndFinish();
  endtask

  function automatic logic [7:0] expByte(input int k);
    return (k < 6) ? (8'h10 + 8'(k)) ^ 8'h5A : (8'h1A + 8'(k)) ^ 8'h5A;
  endfunction

  task automatic scnAddrPin();
    cmpByte(8'(ownSlaveAddr), {1'b0, OWN_ADDR_HI, 1'b1}, "addr1");
    cmpBit(sdaOut | sclOut, 1'b0, "pin out level");
    slaveAddrLsbPin = 1'b0;
    mcyc(4);
    cmpByte(8'(ownSlaveAddr), {1'b0, OWN_ADDR_HI, 1'b0}, "addr0");
  endtask

  task automatic scnBypass();
    spiMode = 1'b1;
    bypassEn = 1'b1;
    mcyc(2);
    cmpBit(bypassSwitch, 1'b0, "switch in spi mode");
    spiMode = 1'b0;
    mcyc(2);
    cmpBit(bypassSwitch, 1'b1, "switch closed");
    // master allowed, yet pass-through keeps it off the pins
    masterEn = 1'b1;
    oeSeen = 0;
    mcyc(1200);
    cmpBit(oeSeen != 0, 1'b0, "aux pins driven in bypass");
  endtask

  task automatic scnFetch();
    fifoQ.delete();
    // sensors set up, hand the bus back to the master
    bypassEn = 1'b0;
    waitHost(1'b0);
    for (int k = 0; k < NB; k++) begin
      cmpByte(extData[8*k +: 8], expByte(k), "ext byte");
    end
    cmpByte(sensor.ptr, 8'h32, "bytes past the limit");
    cmpByte(8'(fifoQ.size()), 8'h06, "fifo pushes");
    for (int k = 0; k < 6; k++) begin
      cmpByte(fifoQ[k], expByte(k), "fifo byte");
    end
  endtask

  task automatic scnNack();
    chanAddr[6:0] = 7'h0D;
    chanEn = 4'h1;
    waitHost(1'b0);
    fifoQ.delete();
    nackSeen = 0;
    waitHost(1'b0);
    cmpByte(8'(nackSeen), 8'h01, "nack events");
    cmpByte({5'h00, nackCh}, 8'h00, "nack channel");
    cmpByte(8'(fifoQ.size()), 8'h00, "pushes after nack");
    cmpByte(extData[15:8], expByte(1), "slot kept");
  endtask

  task automatic ch4Op(input logic wr, input logic [6:0] addr,
                       input logic [7:0] data);
    @(posedge hostClk);
    #2;
    ch4Write = wr;
    ch4Addr = addr;
    ch4Reg = 8'h80;
    ch4WrData = data;
    ch4Go = 1'b1;
    @(posedge hostClk);
    #2;
    ch4Go = 1'b0;
    waitHost(1'b1);
  endtask

  task automatic scnCh4();
    chanEn = 4'h0;
    slow = 1'b1;
    ch4Op(1'b1, MAG_ADDR, 8'h3C);
    cmpBit(ch4Nack, 1'b0, "write acked");
    cmpByte(sensor.mem[8'h80], 8'h3C, "written byte");
    cmpByte(sensor.ptr, 8'h81, "one byte written");
    ch4Op(1'b0, MAG_ADDR, 8'h00);
    cmpByte(ch4RdData, 8'h3C, "read back");
    cmpByte(sensor.ptr, 8'h81, "one byte read");
    ch4Op(1'b0, 7'h0D, 8'h00);
    cmpBit(ch4Nack, 1'b1, "absent sensor");
    cmpByte({5'h00, nackCh}, {5'h00, CH4}, "nack on channel 4");
  endtask

  initial begin
    mismatches = 0;
    nCompared = 0;
    nackSeen = 0;
    oeSeen = 0;
    rst_b = 1'b0;
    masterEn = 1'b0;
    bypassEn = 1'b0;
    spiMode = 1'b0;
    slow = 1'b0;
    chanEn = 4'h7;
    chanFifo = 4'h1;
    chanAddr = {4{MAG_ADDR}};
    chanReg = 32'h0040_2010;
    chanLen = {5'h00, 5'h04, 5'h14, 5'h06};
    ch4Go = 1'b0;
    ch4Write = 1'b0;
    ch4Addr = 7'h00;
    ch4Reg = 8'h00;
    ch4WrData = 8'h00;
    slaveAddrLsbPin = 1'b1;
    mcyc(12);
    rst_b = 1'b1;
    mcyc(4);
    scnAddrPin();
    scnBypass();
    scnFetch();
    scnNack();
    scnCh4();
    tallyAndFinish();
  end
endmodule
`default_nettype wire
